// ---- design/intc_accept.sv ----
// Interrupt request latching, enabling and acceptance sequencing for an 8-bit CPU.
`timescale 1ns/10ps
`default_nettype none

module intc_accept
  import intc_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        arst_n_i,
  input  wire logic [23:0] req_set_i,       // One-cycle set pulses, sources 2..23; bits 0 and 1 are ignored.
  input  wire logic        sfr_wr_i,
  input  wire logic        sfr_rd_i,
  input  wire logic [7:0]  sfr_addr_i,
  input  wire logic [7:0]  sfr_wdata_i,
  output logic      [7:0]  sfr_rdata_o,
  input  wire logic        instr_last_i,    // Final cycle of the current instruction.
  input  wire logic        ret_i,           // Return instruction restoring global enable.
  input  wire logic        ret_imf_i,       // Global enable value popped from the stack.
  output logic             global_enable_o,
  output logic             accept_busy_o,   // Acceptance sequence in progress.
  output logic      [4:0]  accept_src_o,    // Source being accepted.
  output logic             push_o,          // One-cycle push strobe.
  output logic      [1:0]  push_sel_o,      // 0 status word, 1 PC high, 2 PC low.
  output logic             vector_load_o,   // Load PC from vector slot of accept_src_o.
  output logic             sp_dec3_o        // Stack pointer drops by three.
);

  // ==========================================================================
  // Machine-cycle divider.
  // It runs free, so step 0 of a sequence lasts one to four clocks depending on the phase at the start.
  logic [1:0] mcyc_cnt;
  wire        mcyc_en = (mcyc_cnt == MCYC_LAST);

  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      mcyc_cnt <= 2'h0;
    else
      mcyc_cnt <= mcyc_cnt + 2'h1;
  end

  // ==========================================================================
  // Register decode.
  typedef enum {IDLE, SEQ} state_e;
  state_e     state;
  logic [3:0] step;
  logic [23:0] enable;     // Bit 0 is the global enable; 1..3 unused.
  logic [23:0] latch;

  wire wr_en_lo  = sfr_wr_i && (sfr_addr_i == ADDR_ENABLE_LOW);
  wire wr_en_hi  = sfr_wr_i && (sfr_addr_i == ADDR_ENABLE_HIGH);
  wire wr_en_up  = sfr_wr_i && (sfr_addr_i == ADDR_UPPER_ENABLE);
  wire wr_la_lo  = sfr_wr_i && (sfr_addr_i == ADDR_LATCH_LOW);
  wire wr_la_hi  = sfr_wr_i && (sfr_addr_i == ADDR_LATCH_HIGH);
  wire wr_la_up  = sfr_wr_i && (sfr_addr_i == ADDR_UPPER_LATCH);

  // Write-zero-to-clear mask; ones leave the latch alone and never set it.
  wire [23:0] sw_clear = ~{wr_la_up ? sfr_wdata_i : 8'hFF,
                           wr_la_hi ? sfr_wdata_i : 8'hFF,
                           wr_la_lo ? sfr_wdata_i : 8'hFF};

  // ==========================================================================
  // Priority selection over pending requests.
  wire [23:0] maskable_ok = latch & {enable[23:FIRST_MASKABLE], 4'h0}
                            & {24{enable[GLOBAL_ENABLE_BIT]}};
  wire [23:0] eligible    = maskable_ok | {20'h00000, latch[3:2], 2'b00};

  function automatic logic [4:0] first_set(input logic [23:0] v);
    logic [4:0] idx;
    idx = 5'h00;
    for (int i = NUM_SOURCES - 1; i >= 0; i--)
      if (v[i])
        idx = 5'(i);
    return idx;
  endfunction

  wire [4:0] winner   = first_set(eligible);
  wire       start    = (state == IDLE) && instr_last_i && (|eligible);
  wire       last_step = (state == SEQ) && mcyc_en && (step == ACCEPT_LAST);

  // Accept-side clear: taken at the first cycle of the sequence.
  wire [23:0] acc_clear = start ? (24'h000001 << winner) : 24'h000000;

  // ==========================================================================
  // Request latches; a new set beats any clear in the same cycle.
  // Bits 0 and 1 have no source behind them and are never set.
  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      latch <= LATCH_RESET;
    else
      latch <= (latch & ~sw_clear & ~acc_clear) | (req_set_i & 24'hFFFFFC);
  end

  // ==========================================================================
  // Enables and global enable.
  // Acceptance is assigned last so that it wins over a return or a write in the same cycle.
  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      enable <= ENABLE_RESET;
    else
    begin
      if (wr_en_lo)
        enable[7:0] <= {sfr_wdata_i[7:4], 3'b000, sfr_wdata_i[0]};
      if (wr_en_hi)
        enable[15:8] <= sfr_wdata_i;
      if (wr_en_up)
        enable[23:16] <= sfr_wdata_i;
      if (ret_i)
        enable[GLOBAL_ENABLE_BIT] <= ret_imf_i;
      if (start)
        enable[GLOBAL_ENABLE_BIT] <= 1'b0;
    end
  end

  // ==========================================================================
  // Acceptance sequencer, counting machine cycles.
  // A new acceptance cannot start until the vector load has dropped busy.
  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      state        <= IDLE;
      step         <= 4'h0;
      accept_src_o <= 5'h00;
    end
    else
    begin
      case (state)
        IDLE:
        begin
          if (start)
          begin
            state        <= SEQ;
            step         <= 4'h0;
            accept_src_o <= winner;
          end
        end
        SEQ:
        begin
          if (mcyc_en)
          begin
            if (step == ACCEPT_LAST)
              state <= IDLE;
            step <= step + 4'h1;
          end
        end
        default:
          state <= IDLE;
      endcase
    end
  end

  // Stacking strobes in machine cycles 1..3, vector load in the final one.
  // Only PC and status word are stacked; general registers are left to software.
  wire [3:0] push_step = step - 4'h1;
  assign accept_busy_o = (state == SEQ);
  assign push_o        = accept_busy_o && mcyc_en && (step >= 4'h1) && (step <= STACK_FRAME);
  assign push_sel_o    = push_step[1:0];
  assign sp_dec3_o     = accept_busy_o && mcyc_en && (step == STACK_FRAME);
  assign vector_load_o = last_step;
  assign global_enable_o = enable[GLOBAL_ENABLE_BIT];

  // ==========================================================================
  // Read data, registered.
  // Bits 1 to 3 of the low enable byte are stored as zero, so they read back as zero.
  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      sfr_rdata_o <= 8'h00;
    else if (sfr_rd_i)
    begin
      case (sfr_addr_i)
        ADDR_ENABLE_LOW:   sfr_rdata_o <= enable[7:0];
        ADDR_ENABLE_HIGH:  sfr_rdata_o <= enable[15:8];
        ADDR_UPPER_ENABLE: sfr_rdata_o <= enable[23:16];
        ADDR_LATCH_LOW:    sfr_rdata_o <= latch[7:0];
        ADDR_LATCH_HIGH:   sfr_rdata_o <= latch[15:8];
        ADDR_UPPER_LATCH:  sfr_rdata_o <= latch[23:16];
        default:           sfr_rdata_o <= 8'h00;
      endcase
    end
  end

  // ==========================================================================
  // Checks.
  sequence seq_start;
    start;
  endsequence

  AST_GLOBAL_CLEARED: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    seq_start |=> !global_enable_o)
    else $error("Global enable not cleared at acceptance.");

  AST_LATCH_CLEARED: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    seq_start and !req_set_i[winner] |=> !latch[accept_src_o])
    else $error("Accepted latch not cleared.");

  AST_MASKED_REFUSED: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    start && !enable[GLOBAL_ENABLE_BIT] |-> winner < 5'd4)
    else $error("Maskable source taken with global enable low.");

  AST_EIGHT_MCYC: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    seq_start |-> ##[29:32] vector_load_o)
    else $error("Acceptance did not last eight machine cycles.");

  AST_THREE_PUSHES: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    sp_dec3_o |-> push_o && push_sel_o == 2'd2)
    else $error("Stack drop not at the third push.");

  AST_SET_WINS: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    req_set_i[9] |=> latch[9])
    else $error("Latch set lost.");

  AST_WRITE_ONE_KEEPS: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    wr_la_lo && !latch[4] && !req_set_i[4] && !start |=> !latch[4])
    else $error("Writing one set a latch.");

  AST_PRIORITY: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    start |-> (eligible & ((24'h000001 << winner) - 24'h000001)) == 24'h000000)
    else $error("Lower-ranked source accepted first.");

  // An eligible source at an instruction boundary is taken at once; a slip eats the latency budget.
  AST_ACCEPT_PROMPT: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    (state == IDLE) && instr_last_i && (|eligible) |=> accept_busy_o && (accept_src_o == $past(winner)))
    else $error("Eligible request not taken at the instruction boundary.");

  // A maskable winner needs both its own enable and the global enable.
  AST_ENABLE_GATES: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    start && (winner >= 5'(FIRST_MASKABLE)) |-> enable[winner] && enable[GLOBAL_ENABLE_BIT])
    else $error("Maskable source taken without its enables.");

  // Only a latch write or an acceptance may drop a pending request.
  AST_LATCH_HOLDS: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    !start && !wr_la_lo && !wr_la_hi && !wr_la_up |=> (latch & $past(latch)) == $past(latch))
    else $error("Pending request dropped without a clear.");

  // A return loads the popped global enable unless an acceptance clears it in the same cycle.
  AST_RETURN_RESTORES: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    ret_i && !start |=> global_enable_o == $past(ret_imf_i))
    else $error("Return did not restore the global enable.");

  // The source under service must not change before the vector is loaded.
  AST_SEQ_HOLDS: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    accept_busy_o && !vector_load_o |=> accept_busy_o && $stable(accept_src_o))
    else $error("Acceptance sequence cut short.");

  // The vector load is the last step; the core begins the routine on the next cycle.
  AST_SEQ_ENDS: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    vector_load_o |=> !accept_busy_o)
    else $error("Sequence still busy after the vector load.");

  // Stack and vector strobes outside a sequence would corrupt the core's stack.
  AST_IDLE_QUIET: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    !accept_busy_o |-> !push_o && !sp_dec3_o && !vector_load_o)
    else $error("Stack or vector strobe outside acceptance.");

  // The frame goes out one byte per machine cycle: status word, PC high, then PC low.
  sequence seq_push_status;
    push_o && (push_sel_o == 2'h0);
  endsequence

  sequence seq_push_pc;
    ##4 push_o && (push_sel_o == 2'h1) ##4 push_o && (push_sel_o == 2'h2) && sp_dec3_o;
  endsequence

  AST_PUSH_ORDER: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    seq_push_status |-> seq_push_pc)
    else $error("Stack frame pushed out of order.");

endmodule : intc_accept

`default_nettype wire

// ---- design/intc_pkg.sv ----
// Package with the register map, reset values and timing constants of the interrupt controller.
package intc_pkg;

  // ==========================================================================
  // Register addresses, in the special-function register byte space.
  localparam logic [7:0] ADDR_UPPER_ENABLE  = 8'h2C;
  localparam logic [7:0] ADDR_UPPER_LATCH   = 8'h2E;
  localparam logic [7:0] ADDR_ENABLE_LOW    = 8'h3A;
  localparam logic [7:0] ADDR_ENABLE_HIGH   = 8'h3B;
  localparam logic [7:0] ADDR_LATCH_LOW     = 8'h3C;
  localparam logic [7:0] ADDR_LATCH_HIGH    = 8'h3D;

  // ==========================================================================
  // Field positions and reset values.
  localparam int          GLOBAL_ENABLE_BIT = 0;
  localparam int          FIRST_MASKABLE    = 4;
  localparam int          NUM_SOURCES       = 24;
  localparam logic [23:0] ENABLE_RESET      = 24'h000000;
  localparam logic [23:0] LATCH_RESET       = 24'h000000;

  // ==========================================================================
  // Timing of the acceptance sequence, in machine-cycle enables; WORST_LATENCY_CLK is in clocks.
  localparam int          ACCEPT_CYCLES     = 8;
  localparam int          WORST_LATENCY_CLK = 38;
  localparam logic [3:0]  ACCEPT_LAST       = 4'(ACCEPT_CYCLES - 1);
  localparam logic [3:0]  STACK_FRAME       = 4'h3;

  // Machine cycle is one enable every MCYC_DIV clocks.
  localparam int          MCYC_DIV          = 4;
  localparam logic [1:0]  MCYC_LAST         = 2'(MCYC_DIV - 1);

endpackage : intc_pkg

// ---- test/cpu_core_model.sv ----
// Behavioural CPU core: instruction boundaries and the stack pointer.
`timescale 1ns/10ps
`default_nettype none
// ==========================================================================
// Core model
module cpu_core_model
(
  input  wire logic       clk_i,
  input  wire logic       arst_n_i,
  input  wire logic       sp_dec3_i,
  input  wire logic       ret_i,
  output logic            instr_last_o,
  output logic      [7:0] sp_o
);
  logic [1:0] phase;
  // Every instruction lasts four clocks, which keeps the sampling point frequent.
  assign instr_last_o = (phase == 2'h3);
  // The stack frame is three bytes in both directions.
  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      phase <= 2'h0;
      sp_o  <= 8'hFF;
    end
    else
    begin
      phase <= phase + 2'h1;
      sp_o  <= sp_o - (sp_dec3_i ? 8'h03 : 8'h00) + (ret_i ? 8'h03 : 8'h00);
    end
  end
endmodule // cpu_core_model
`default_nettype wire

// ---- test/mcu_interrupt_enable_and_accept_bench.sv ----
// Self-checking bench of the interrupt acceptance block.
`timescale 1ns/10ps
`default_nettype none
// ==========================================================================
// Bench
module mcu_interrupt_enable_and_accept_bench
  import intc_pkg::*;
;
  logic        clk_i = 0, arst_n_i = 0, sfr_wr_i = 0, sfr_rd_i = 0, ret_i = 0, ret_imf_i = 0;
  logic [23:0] req_set_i = '0;
  logic [7:0]  sfr_addr_i = '0, sfr_wdata_i = '0, sfr_rdata_o, sp, sp0;
  logic        instr_last, global_enable_o, accept_busy_o, push_o, vector_load_o, sp_dec3_o;
  logic [4:0]  accept_src_o;
  logic [1:0]  push_sel_o;
  int          err_total = 0, num_checks = 0, seed = 16, s, c, np;
  logic [7:0]  adr [6] = '{8'h2C, 8'h2E, 8'h3A, 8'h3B, 8'h3C, 8'h3D};

  initial forever #10 clk_i = ~clk_i;

  intc_accept dut (.clk_i(clk_i), .arst_n_i(arst_n_i), .req_set_i(req_set_i), .sfr_wr_i(sfr_wr_i),
    .sfr_rd_i(sfr_rd_i), .sfr_addr_i(sfr_addr_i), .sfr_wdata_i(sfr_wdata_i), .sfr_rdata_o(sfr_rdata_o),
    .instr_last_i(instr_last), .ret_i(ret_i), .ret_imf_i(ret_imf_i), .global_enable_o(global_enable_o),
    .accept_busy_o(accept_busy_o), .accept_src_o(accept_src_o), .push_o(push_o), .push_sel_o(push_sel_o),
    .vector_load_o(vector_load_o), .sp_dec3_o(sp_dec3_o));
  cpu_core_model core (.clk_i(clk_i), .arst_n_i(arst_n_i), .sp_dec3_i(sp_dec3_o), .ret_i(ret_i),
    .instr_last_o(instr_last), .sp_o(sp));

  // Where a source's enable bit lives, worked out independently of the design.
  function automatic logic [7:0] ea(int n);
    return n < 8 ? ADDR_ENABLE_LOW : (n < 16 ? ADDR_ENABLE_HIGH : ADDR_UPPER_ENABLE);
  endfunction
  function automatic logic [7:0] bm(int n);
    return 8'(1 << (n % 8));
  endfunction

  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    num_checks++;
    if (g !== e)
    begin
      err_total++;
      $display("BAD %0t got %h expected %h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i) {sfr_wr_i, sfr_addr_i, sfr_wdata_i} <= {1'b1, a, d};
    @(posedge clk_i) sfr_wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk_i) {sfr_rd_i, sfr_addr_i} <= {1'b1, a};
    @(posedge clk_i) sfr_rd_i <= 1'b0;
    #1 chk(sfr_rdata_o, e);
  endtask
  task automatic pulse(input int n);
    @(posedge clk_i) req_set_i <= 24'(1) << n;
    @(posedge clk_i) req_set_i <= '0;
  endtask
  // Busy must stay low for the whole span.
  task automatic idle(input int n);
    repeat (n)
    begin
      @(posedge clk_i);
      #1 chk(8'(accept_busy_o), 8'h00);
    end
  endtask
  // Waits for acceptance of source n and follows the whole sequence.
  // Busy is first seen in the cycle after the start edge, so c then counts clocks from that edge.
  task automatic take(input int n);
    c = 0;
    while (accept_busy_o !== 1'b1 && c < 40)
    begin
      @(posedge clk_i);
      #1 c++;
    end
    chk(8'(c <= WORST_LATENCY_CLK), 8'h01);
    chk(8'(accept_src_o), 8'(n));
    chk(8'(global_enable_o), 8'h00);
    sp0 = sp;
    np = 0;
    c = 1;
    while (vector_load_o !== 1'b1 && c < 40)
    begin
      @(posedge clk_i);
      #1 c++;
      if (push_o === 1'b1)
      begin
        chk(8'(push_sel_o), 8'(np));
        np++;
      end
    end
    chk(8'(np), 8'h03);
    chk(8'(c > (ACCEPT_CYCLES - 1) * MCYC_DIV && c <= ACCEPT_CYCLES * MCYC_DIV), 8'h01);
    chk(sp, sp0 - 8'h03);
    rd(n < 8 ? ADDR_LATCH_LOW : (n < 16 ? ADDR_LATCH_HIGH : ADDR_UPPER_LATCH), 8'h00);
  endtask
  task automatic ret(input logic global_maskable_enable);
    @(posedge clk_i) {ret_i, ret_imf_i} <= {1'b1, global_maskable_enable};
    @(posedge clk_i) ret_i <= 1'b0;
    #1 chk(8'(global_enable_o), 8'(global_maskable_enable));
    chk(sp, sp0);
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // Main sequence: reset map, masking, latch writes, priority, random sources.
  initial
  begin
    repeat (8) @(posedge clk_i);
    arst_n_i <= 1'b1;
    foreach (adr[i]) rd(adr[i], 8'h00);
    rd(8'h30, 8'h00);
    wr(ADDR_ENABLE_LOW, 8'hFE);
    rd(ADDR_ENABLE_LOW, 8'hF0);
    wr(ADDR_ENABLE_LOW, 8'h00);
    pulse(6);
    rd(ADDR_LATCH_LOW, 8'h40);
    wr(ADDR_ENABLE_LOW, 8'h01);
    idle(40);
    wr(ADDR_ENABLE_LOW, 8'h00);
    wr(ADDR_LATCH_LOW, 8'hFF);
    rd(ADDR_LATCH_LOW, 8'h40);
    wr(ADDR_LATCH_LOW, 8'hBF);
    rd(ADDR_LATCH_LOW, 8'h00);
    pulse(3);
    take(3);
    ret(1'b0);
    pulse(2);
    take(2);
    ret(1'b0);
    wr(ADDR_ENABLE_HIGH, bm(9));
    wr(ADDR_ENABLE_LOW, bm(5));
    pulse(9);
    pulse(5);
    idle(12);
    wr(ADDR_ENABLE_LOW, bm(5) | 8'h01);
    take(5);
    idle(12);
    wr(ADDR_ENABLE_LOW, 8'h00);
    ret(1'b1);
    take(9);
    ret(1'b0);
    repeat (6)
    begin
      s = 4 + ($unsigned($random(seed)) % 20);
      wr(ADDR_ENABLE_LOW, 8'h00);
      wr(ADDR_ENABLE_HIGH, 8'h00);
      wr(ADDR_UPPER_ENABLE, 8'h00);
      wr(ea(s), bm(s));
      pulse(s);
      wr(ADDR_ENABLE_LOW, (ea(s) == ADDR_ENABLE_LOW ? bm(s) : 8'h00) | 8'h01);
      take(s);
      ret(1'b0);
    end
    conclude();
  end

  // A hang counts as a mismatch; the sequence needs well under 5,000 clocks.
  initial
  begin
    #(20 * 20000);
    err_total++;
    conclude();
  end
endmodule // mcu_interrupt_enable_and_accept_bench
`default_nettype wire
